//--- verilog/usart_rx_top.sv
// asynchronous serial receiver with AHB-Lite register access and host pacing flags
// assumes rxd is asynchronous and receiver_bit_clock runs free at 16x or 64x the bit rate
// assumes control is rewritten only while the receiver is disabled
`timescale 1ns/1ps
`include "usart_rx_cfg.svh"
// Functional notes
// (RULE1) host spaces command writes by 8 clocks async, 18 sync.
// (RULE2) host writes transmit data only while transmit ready reads 1.
// (RULE3) host reads receive data only while receive ready reads 1.
// (RULE4) host spaces mode-setup control writes by at least 6 clocks.
// (RULE5) host spaces status reads by at least 6 clocks.
// (RULE6) any status-changing event shows in status within 28 clocks.
// (RULE7) low pulses under 7 (x16) or 31 (x64) ticks start nothing.
// (RULE8) low of 9..16 (x16) or 33..64 (x64) ticks starts a character.
// (RULE9) an exactly 8 or 32 tick low is handled consistently: ignored.
// (RULE10) break ending between last data bit and parity sets parity error, no ready.
// (RULE11) that parity error stays and marks the next normal character too.
// (RULE12) break ending elsewhere sets no parity error and no receive ready.
// (RULE13) start confirmed near mid-bit, later bits sampled at their centres.
module usart_rx_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic receiver_bit_clock,
  input wire logic rxd,
  output logic receive_ready_flag,
  output logic transmit_ready_flag,
  output logic [7:0] tx_data,
  output logic tx_loaded,
  input wire logic tx_taken
);
  usart_rx_pkg::sys_regs_t s;
  usart_rx_pkg::sys_regs_t next_s;
  usart_rx_pkg::link_regs_t l;
  usart_rx_pkg::link_regs_t next_l;

  logic link_rst;
  logic rx_s;
  logic [5:0] ctl_l;
  logic break_s;
  logic char_pulse;
  logic brk_perr_pulse;
  logic [6:0] bit_ticks;
  logic [6:0] confirm;
  logic [3:0] nbits;
  logic [3:0] last_slot;
  logic [3:0] parity_slot;
  logic addr_ok;
  logic [31:0] status_word;
  logic rd_data_now;

  // link side: reset, line and control all cross on the bit clock
  usart_sync2 #(.WIDTH(1)) u_rst_sync (
    .clk(receiver_bit_clock),
    .d(sys_rst),
    .q(link_rst)
  );

  usart_sync2 #(.WIDTH(1)) u_rxd_sync (
    .clk(receiver_bit_clock),
    .d(rxd),
    .q(rx_s)
  );

  // control is quasi-static; change it only with the receiver disabled
  usart_sync2 #(.WIDTH(6)) u_ctl_sync (
    .clk(receiver_bit_clock),
    .d(s.control[5:0]),
    .q(ctl_l)
  );

  // both counts follow the synchronised mode bit, never the host copy
  always_comb begin
    if (ctl_l[`CT_X64]) begin
      bit_ticks = `BIT_TICKS_X64;
      confirm = `START_CONFIRM_X64;
    end else begin
      bit_ticks = `BIT_TICKS_X16;
      confirm = `START_CONFIRM_X16;
    end
  end

  assign nbits = `BASE_CHAR_BITS + {2'h0, ctl_l[`CT_LEN_HI:`CT_LEN_LO]};
  assign parity_slot = nbits + 4'h1;
  assign last_slot = nbits + {3'h0, ctl_l[`CT_PARITY_EN]} + 4'h1;

  always_comb begin
    next_l = l;
    case (l.state)
      usart_rx_pkg::L_IDLE: begin
        // count consecutive low samples; any high sample discards the pulse
        if (!ctl_l[`CT_RX_ENABLE] || rx_s) begin
          next_l.tick = 7'h00; // RULE7 RULE9
        end else if (l.tick == confirm - 7'h01) begin
          // ninth (x16) or 33rd (x64) low in a row; an 8 or 32 tick pulse falls one short
          // and is dropped like any glitch, so it can never raise ready mid-frame
          next_l.state = usart_rx_pkg::L_DATA; // RULE8 RULE13
          next_l.tick = 7'h00;
          next_l.bit_idx = 4'h0;
          next_l.shift = 8'h00;
          next_l.parity = ctl_l[`CT_PARITY_ODD];
          next_l.all_zero = 1'b1;
        end else begin
          next_l.tick = l.tick + 7'h01;
        end
      end
      usart_rx_pkg::L_DATA: begin
        // disabling mid-frame drops the partial character
        if (!ctl_l[`CT_RX_ENABLE]) begin
          next_l.state = usart_rx_pkg::L_IDLE;
          next_l.tick = 7'h00;
        end else if (l.tick == bit_ticks - 7'h01) begin
          // one bit time after mid-start lands at each bit centre
          next_l.tick = 7'h00; // RULE13
          if (l.bit_idx < nbits) begin
            next_l.shift[l.bit_idx[2:0]] = rx_s;
            next_l.parity = l.parity ^ rx_s;
            next_l.all_zero = l.all_zero & ~rx_s;
            next_l.bit_idx = l.bit_idx + 4'h1;
          end else if (l.bit_idx == nbits && ctl_l[`CT_PARITY_EN]) begin
            next_l.parity = l.parity ^ rx_s;
            next_l.all_zero = l.all_zero & ~rx_s;
            next_l.bit_idx = l.bit_idx + 4'h1;
          end else if (l.all_zero && !rx_s) begin
            // whole frame low: break; no character, no ready
            next_l.state = usart_rx_pkg::L_BREAK; // RULE12
            next_l.bit_idx = 4'h0;
          end else begin
            next_l.state = usart_rx_pkg::L_IDLE;
            next_l.word = l.shift;
            next_l.word_perr = (ctl_l[`CT_PARITY_EN] & l.parity) | l.sticky_perr; // RULE11
            next_l.word_ferr = ~rx_s;
            next_l.sticky_perr = 1'b0;
            next_l.char_tog = ~l.char_tog;
          end
        end else begin
          next_l.tick = l.tick + 7'h01;
        end
      end
      usart_rx_pkg::L_BREAK: begin
        // slots keep running through phantom frames while the line stays low
        if (rx_s || !ctl_l[`CT_RX_ENABLE]) begin
          next_l.state = usart_rx_pkg::L_IDLE;
          next_l.tick = 7'h00;
          // a rise between the last data sample and the parity sample marks the next character
          if (rx_s && ctl_l[`CT_PARITY_EN] && l.bit_idx == parity_slot) begin
            next_l.sticky_perr = 1'b1; // RULE10
            next_l.brk_perr_tog = ~l.brk_perr_tog; // RULE10
          end
        end else if (l.tick == bit_ticks - 7'h01) begin
          next_l.tick = 7'h00;
          next_l.bit_idx = (l.bit_idx == last_slot) ? 4'h0 : l.bit_idx + 4'h1;
        end else begin
          next_l.tick = l.tick + 7'h01;
        end
      end
      default: begin
        next_l.state = usart_rx_pkg::L_IDLE;
      end
    endcase
    // registered so the crossing never sees a decode glitch between states
    next_l.in_break = (next_l.state == usart_rx_pkg::L_BREAK);
  end

  always_ff @(posedge receiver_bit_clock) begin
    // link reset is sys_rst seen through two bit clock flops
    if (link_rst) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // system side: events come back as toggles, break as a level
  usart_pulse_xing u_char_xing (
    .clk(clk_sys),
    .rst(sys_rst),
    .tog(l.char_tog),
    .pulse(char_pulse)
  );

  usart_pulse_xing u_brk_xing (
    .clk(clk_sys),
    .rst(sys_rst),
    .tog(l.brk_perr_tog),
    .pulse(brk_perr_pulse)
  );

  usart_sync2 #(.WIDTH(1)) u_brk_sync (
    .clk(clk_sys),
    .d(l.in_break),
    .q(break_s)
  );

  // zero wait states: an accepted address phase is answered in the next cycle
  assign addr_ok = hsel && hready && htrans[1];
  // a data read meeting a new character in one cycle is not an overrun
  assign rd_data_now = addr_ok && !hwrite && haddr[7:0] == `ADDR_DATA;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`ST_RX_READY] = s.rx_ready;
    status_word[`ST_TX_READY] = ~s.tx_loaded;
    status_word[`ST_PARITY_ERR] = s.perr;
    status_word[`ST_FRAMING_ERR] = s.ferr;
    status_word[`ST_OVERRUN] = s.overrun;
    status_word[`ST_BREAK] = break_s;
  end

  always_comb begin
    next_s = s;
    next_s.ph_valid = addr_ok;
    next_s.ph_write = hwrite;
    next_s.ph_addr = haddr[7:0];
    // transmitter hand-off; a data write in the same cycle still tests the old tx_loaded below and is dropped
    if (tx_taken) begin
      next_s.tx_loaded = 1'b0;
    end
    // address phase: reads resolve here so data stands from a flop
    if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        `ADDR_DATA: begin
          next_s.rdata = {24'h000000, s.rx_buf};
          next_s.rx_ready = 1'b0; // RULE3
        end
        `ADDR_STATUS: begin
          next_s.rdata = status_word; // RULE6
        end
        `ADDR_CONTROL: begin
          next_s.rdata = {24'h000000, s.control};
        end
        default: begin
          next_s.rdata = 32'h0000_0000;
        end
      endcase
    end
    // data phase writes
    if (s.ph_valid && s.ph_write) begin
      case (s.ph_addr)
        `ADDR_DATA: begin
          // a write with transmit ready low is dropped
          if (!s.tx_loaded) begin
            next_s.tx_buf = hwdata[7:0]; // RULE2
            next_s.tx_loaded = 1'b1;
          end
        end
        `ADDR_CONTROL: next_s.control = hwdata[7:0]; // RULE4
        `ADDR_COMMAND: begin
          if (hwdata[`CMD_ERROR_RESET]) begin
            next_s.perr = 1'b0; // RULE1
            next_s.ferr = 1'b0;
            next_s.overrun = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // hardware sets come last so they win over reads and error reset
    // word and its flags load with the toggle and then hold a whole frame, so they are stable when it lands here
    if (char_pulse) begin
      next_s.rx_buf = l.word; // RULE6
      next_s.rx_ready = 1'b1; // RULE6
      if (s.rx_ready && !rd_data_now) begin
        next_s.overrun = 1'b1;
      end
      if (l.word_perr) begin
        next_s.perr = 1'b1; // RULE11
      end
      if (l.word_ferr) begin
        next_s.ferr = 1'b1;
      end
    end
    if (brk_perr_pulse) begin
      next_s.perr = 1'b1; // RULE10
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      // control returns enabled, x16, 8 bits, no parity
      s <= '0;
      s.control <= `CONTROL_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign receive_ready_flag = s.rx_ready;
  assign transmit_ready_flag = ~s.tx_loaded;
  assign tx_data = s.tx_buf;
  assign tx_loaded = s.tx_loaded;
endmodule : usart_rx_top

//--- inc/usart_rx_cfg.svh
// register map, field positions, reset values and receiver timing counts
// assumes one 256-byte AHB-Lite window; upper address bits are not decoded
`ifndef USART_RX_CFG_SVH
`define USART_RX_CFG_SVH
`define ADDR_DATA 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_CONTROL 8'h08
`define ADDR_COMMAND 8'h0c
`define ST_RX_READY 0
`define ST_TX_READY 1
`define ST_PARITY_ERR 2
`define ST_FRAMING_ERR 3
`define ST_OVERRUN 4
`define ST_BREAK 5
`define CT_RX_ENABLE 0
`define CT_X64 1
`define CT_PARITY_EN 2
`define CT_PARITY_ODD 3
`define CT_LEN_LO 4
`define CT_LEN_HI 5
`define CMD_ERROR_RESET 0
`define CONTROL_RESET 8'h31
`define BIT_TICKS_X16 7'h10
`define BIT_TICKS_X64 7'h40
`define START_CONFIRM_X16 7'h09
`define START_CONFIRM_X64 7'h21
`define BASE_CHAR_BITS 4'h5
`endif

//--- inc/usart_rx_pkg.sv
// state types of the receiver and its register side
// assumes usart_rx_cfg.svh is on the include path
`include "usart_rx_cfg.svh"
package usart_rx_pkg;
  typedef enum logic [1:0] {L_IDLE, L_DATA, L_BREAK} link_state_t;

  typedef struct packed {
    link_state_t state;
    logic [6:0] tick;
    logic [3:0] bit_idx;
    logic [7:0] shift;
    logic parity;
    logic all_zero;
    logic sticky_perr;
    logic [7:0] word;
    logic word_perr;
    logic word_ferr;
    logic char_tog;
    logic brk_perr_tog;
    logic in_break;
  } link_regs_t;

  typedef struct packed {
    logic rx_ready;
    logic perr;
    logic ferr;
    logic overrun;
    logic tx_loaded;
    logic [7:0] rx_buf;
    logic [7:0] tx_buf;
    logic [7:0] control;
    logic [31:0] rdata;
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
  } sys_regs_t;
endpackage : usart_rx_pkg

//--- verilog/usart_sync2.sv
// two flip-flop synchroniser for levels that change slowly
// assumes each bit is independent or held stable while it crosses
`timescale 1ns/1ps
module usart_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule : usart_sync2

//--- verilog/usart_pulse_xing.sv
// turns a toggle from another clock domain into a one-cycle pulse here
// assumes the source toggles no faster than every three destination edges
`timescale 1ns/1ps
module usart_pulse_xing (
  input wire logic clk,
  input wire logic rst,
  input wire logic tog,
  output logic pulse
);
  logic meta;
  logic sync;
  logic last;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= tog;
      sync <= meta;
      last <= sync;
    end
  end

  assign pulse = sync ^ last;
endmodule : usart_pulse_xing

//--- verif/serial_line_model.sv
// serial line partner: drives rxd in receiver clock ticks, idle high
// assumes the receiver clock runs free and the bench calls its tasks
`timescale 1ns/1ps
module serial_line_model (
  input wire logic receiver_bit_clock,
  output logic rxd
);
  initial rxd = 1'b1;
  task automatic hold(input logic v, input int n);
    rxd <= v;
    repeat (n) @(posedge receiver_bit_clock);
  endtask : hold
  task automatic low(input int n, input int idle);
    @(posedge receiver_bit_clock);
    hold(1'b0, n);
    hold(1'b1, idle);
  endtask : low
  // short start, high to slot edge, lsb first, even parity
  task automatic frame(input logic [7:0] d, input int s, input int b, input logic p);
    @(posedge receiver_bit_clock);
    hold(1'b0, s);
    if (s < b) hold(1'b1, b - s);
    for (int i = 0; i < 8; i++) hold(d[i], b);
    if (p) hold(^d, b);
    hold(1'b1, 48);
  endtask : frame
endmodule : serial_line_model

//--- verif/usart_rx_chk.sv
// checker: bus, flag and reset relations at the receiver top
// assumes one clk_sys domain at the watched ports
`timescale 1ns/1ps
`include "usart_rx_cfg.svh"
module usart_rx_chk (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic receive_ready_flag,
  input wire logic transmit_ready_flag,
  input wire logic tx_loaded,
  input wire logic tx_taken
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic rd_req;
  logic dat;
  assign rd_req = hsel && htrans[1] && !hwrite;
  assign dat = hsel && htrans[1] && haddr[7:0] == `ADDR_DATA;
  a_zero_wait: assert property (hreadyout && !hresp) else $error("wait state or error response");
  a_tx_flag: assert property (transmit_ready_flag == !tx_loaded) else $error("tx ready not inverse");
  a_read_stable: assert property (!rd_req |=> $stable(hrdata)) else $error("hrdata moved");
  a_rx_clear: assert property (dat && !hwrite |=> !receive_ready_flag) else $error("rx ready kept");
  a_rx_hold: assert property (
    receive_ready_flag && !(dat && !hwrite) |=> receive_ready_flag) else $error("rx ready lost");
  a_tx_load: assert property (dat && hwrite && transmit_ready_flag |-> ##2 tx_loaded) else $error("no load");
  a_tx_drain: assert property (tx_taken |=> !tx_loaded) else $error("tx_loaded stuck");
  a_reset_out: assert property ($fell(sys_rst) |-> !receive_ready_flag && transmit_ready_flag
    && hrdata == 32'h0) else $error("bad reset outputs");
  cover property ($rose(receive_ready_flag));
  cover property (dat && hwrite && !transmit_ready_flag);
  cover property ($fell(tx_loaded));
endmodule : usart_rx_chk
bind usart_rx_top usart_rx_chk chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .receive_ready_flag(receive_ready_flag), .transmit_ready_flag(transmit_ready_flag),
  .tx_loaded(tx_loaded), .tx_taken(tx_taken));

//--- verif/usart_rx_start_and_host_pacing_tb.sv
// bench: AHB-Lite master, serial line partner, queued read checks
// assumes hready looped back from hreadyout
`timescale 1ns/1ps
`include "usart_rx_cfg.svh"
module usart_rx_start_and_host_pacing_tb;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic receiver_bit_clock = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic tx_taken = 1'b0;
  logic hreadyout, hresp, receive_ready_flag, transmit_ready_flag, tx_loaded, rxd;
  logic [31:0] hrdata;
  logic [7:0] tx_data;
  logic [31:0] rnd = 32'h611f;
  logic [31:0] qe[$];
  logic [31:0] qm[$];
  logic rd_ph = 1'b0;
  int err_count = 0;
  int checks = 0;
  always #25 clk_sys = ~clk_sys;
  always #24 receiver_bit_clock = ~receiver_bit_clock;
  usart_rx_top uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .receiver_bit_clock(receiver_bit_clock), .rxd(rxd),
    .receive_ready_flag(receive_ready_flag), .transmit_ready_flag(transmit_ready_flag),
    .tx_data(tx_data), .tx_loaded(tx_loaded), .tx_taken(tx_taken));
  serial_line_model far (.receiver_bit_clock(receiver_bit_clock), .rxd(rxd));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic end_sim;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // bounded wait for hready; a hang ends the run
  task automatic step;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (n >= 16) begin
      chk("timeout", 1, 0);
      end_sim;
    end
  endtask : step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    step;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    step;
    // host recovery gap between any two accesses
    repeat (6) @(posedge clk_sys);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    qe.push_back(e);
    qm.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic wait_rx;
    int n;
    n = 0;
    while (receive_ready_flag !== 1'b1 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 2000) begin
      chk("timeout", 1, 0);
      end_sim;
    end
  endtask : wait_rx
  // read data is taken at the edge that ends the data phase
  always @(posedge clk_sys) begin
    if (rd_ph && qe.size() > 0)
      chk("hrdata", qe.pop_front(), hrdata & qm.pop_front());
    rd_ph = hsel && htrans[1] && !hwrite;
  end
  initial begin
    int b;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(`ADDR_STATUS, 32'h2, '1);
    rd(`ADDR_CONTROL, `CONTROL_RESET, '1);
    bus(1'b1, 8'h10, 32'hff);
    rd(8'h10, 32'h0, '1);
    rnd = lfsr(rnd);
    chk("transmit_ready_flag", 1, transmit_ready_flag);
    bus(1'b1, `ADDR_DATA, rnd);
    bus(1'b1, `ADDR_DATA, ~rnd);
    @(negedge clk_sys);
    chk("tx_data", rnd[7:0], tx_data);
    chk("transmit_ready_flag", 0, transmit_ready_flag);
    @(posedge clk_sys);
    tx_taken <= 1'b1;
    @(posedge clk_sys);
    tx_taken <= 1'b0;
    @(negedge clk_sys);
    chk("tx_loaded", 0, tx_loaded);
    $display("test registers and transmit done");
    for (int m = 0; m < 2; m++) begin
      b = m ? 64 : 16;
      bus(1'b1, `ADDR_CONTROL, 32'h30);
      bus(1'b1, `ADDR_CONTROL, 32'h31 | (m << 1));
      far.low(b / 2 - 2, 400);
      far.low(b / 2, 400);
      rd(`ADDR_STATUS, 32'h2, '1);
      rnd = lfsr(rnd);
      far.frame(rnd[7:0], b / 2 + 1, b, 1'b0);
      wait_rx;
      rd(`ADDR_DATA, rnd[7:0], '1);
      rd(`ADDR_STATUS, 32'h2, '1);
      $display("test start filter done");
    end
    bus(1'b1, `ADDR_CONTROL, 32'h30);
    bus(1'b1, `ADDR_CONTROL, 32'h35);
    far.low(260, 400);
    rd(`ADDR_STATUS, 32'h2, 32'h7);
    far.low(322, 400);
    rd(`ADDR_STATUS, 32'h6, 32'h7);
    // clear the flag so only the carried-over mark can set it again
    bus(1'b1, `ADDR_COMMAND, 32'h1);
    rd(`ADDR_STATUS, 32'h2, 32'h7);
    rnd = lfsr(rnd);
    far.frame(rnd[7:0], 16, 16, 1'b1);
    wait_rx;
    rd(`ADDR_STATUS, 32'h7, 32'h7);
    rd(`ADDR_DATA, rnd[7:0], '1);
    bus(1'b1, `ADDR_COMMAND, 32'h1);
    rd(`ADDR_STATUS, 32'h2, 32'h7);
    $display("test break parity done");
    end_sim;
  end
endmodule : usart_rx_start_and_host_pacing_tb
